// ---- rtl/flash_program_erase_suspend.sv ----
`timescale 1ns/10ps
`default_nettype none

module flash_program_erase_suspend
   import suspend_pkg::*;
(
   input  wire logic                CORE_CLK,        // Core clock, 125 MHz
   input  wire logic                RST_N,           // Synchronous reset, active low
   input  wire logic                SCK,             // Serial clock pin
   input  wire logic                CS_N,            // Chip select pin, active low
   input  wire logic                SI,              // Serial data in pin
   input  wire logic                RESET_PIN_N,     // Device reset pin, active low
   input  wire logic                SW_RESET,        // Software reset decoded, pulse
   input  wire logic                CMD_VALID,       // Decoded command offered, pulse
   input  wire cmd_req_t            CMD_REQ,         // Class and buffer of command
   input  wire logic                OP_START,        // Array operation starting, pulse
   input  wire op_req_t             OP_REQ,          // Kind and sector of operation
   input  wire logic                OP_DONE,         // Running operation finished, pulse
   input  wire logic [SECTOR_W-1:0] RD_SECTOR,       // Sector of current read address
   output logic                     CMD_ACCEPT,      // Command permitted, pulse
   output logic                     CMD_REFUSE,      // Command refused, pulse
   output logic                     OP_ABORT,        // Program start aborted, pulse
   output logic                     HOLD_PROG,       // Program engine must stay halted
   output logic                     HOLD_ERASE,      // Erase engine must stay halted
   output logic                     READY,           // Ready/busy flag, 1 is ready
   output logic                     buf_one_prog_suspended, // Buffer-1 program suspended
   output logic                     buf_two_prog_suspended, // Buffer-2 program suspended
   output logic                     erase_suspended_flag,   // Erase suspended
   output logic                     RD_UNDEF,        // Read data must be undefined
   output logic                     UNDEF_VALID,     // Contents lost by reset, pulse
   output undef_t                   UNDEF_INFO       // Which sector or page was lost
);

   typedef enum logic [2:0]
   {
      ST_IDLE    = 3'b001,
      ST_SUSPEND = 3'b010,
      ST_RESUME  = 3'b100
   } seq_state_t;

   // Pin synchronisers; stage one is read only by stage two
   logic [1:0]               sck_sync_reg;
   logic [1:0]               cs_sync_reg;
   logic [1:0]               si_sync_reg;
   logic [1:0]               rstp_sync_reg;
   logic                     sck_prev_reg;
   logic                     cs_prev_reg;
   logic                     rstp_prev_reg;

   logic [BIT_CNT_W-1:0]     bit_cnt_reg;
   logic [7:0]               shift_reg;
   logic [7:0]               opcode_reg;
   logic                     have_opc_reg;

   seq_state_t               state_reg;
   seq_state_t               state_next;
   logic [CNT_W-1:0]         cnt_reg;
   logic [CNT_W-1:0]         cnt_next;
   logic                     tgt_prog_reg;

   logic                     prog_act_reg;
   logic                     prog_buf_reg;
   logic                     prog_page_reg;
   logic [SECTOR_W-1:0]      prog_sect_reg;
   logic                     ps1_reg;
   logic                     ps2_reg;
   logic                     erase_act_reg;
   logic                     erase_page_reg;
   logic [SECTOR_W-1:0]      erase_sect_reg;
   logic                     es_reg;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         sck_sync_reg  <= 2'h0;
         cs_sync_reg   <= 2'h3;
         si_sync_reg   <= 2'h0;
         rstp_sync_reg <= 2'h3;
         sck_prev_reg  <= 1'b0;
         cs_prev_reg   <= 1'b1;
         rstp_prev_reg <= 1'b1;
      end
      else
      begin
         sck_sync_reg  <= {sck_sync_reg[0], SCK};
         cs_sync_reg   <= {cs_sync_reg[0], CS_N};
         si_sync_reg   <= {si_sync_reg[0], SI};
         rstp_sync_reg <= {rstp_sync_reg[0], RESET_PIN_N};
         sck_prev_reg  <= sck_sync_reg[1];
         cs_prev_reg   <= cs_sync_reg[1];
         rstp_prev_reg <= rstp_sync_reg[1];
      end
   end

   wire sck_rise  = sck_sync_reg[1] & ~sck_prev_reg;
   wire cs_low    = ~cs_sync_reg[1];
   wire cs_rise   = cs_sync_reg[1] & ~cs_prev_reg;
   wire bit_in    = si_sync_reg[1];
   // Held reset pin keeps the sequencer and operation tracking cleared, not just its edge
   wire reset_evt = SW_RESET | ~rstp_sync_reg[1];
   wire rstp_fall = ~rstp_sync_reg[1] & rstp_prev_reg;

   // Only the first byte of a frame is kept; later bytes fall away
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || !cs_low)
      begin
         bit_cnt_reg  <= 3'h0;
         shift_reg    <= BYTE_RST;
         if (!RST_N)
         begin
            opcode_reg   <= BYTE_RST;
            have_opc_reg <= 1'b0;
         end
         else if (cs_rise)
         begin
            have_opc_reg <= 1'b0;
         end
      end
      else if (sck_rise && !have_opc_reg)
      begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         shift_reg   <= {shift_reg[6:0], bit_in};
         if (bit_cnt_reg == LAST_BIT)
         begin
            opcode_reg   <= {shift_reg[6:0], bit_in};
            have_opc_reg <= 1'b1;
         end
      end
   end

   wire susp_cmd   = cs_rise & have_opc_reg & (opcode_reg == OPC_SUSPEND);
   wire resume_cmd = cs_rise & have_opc_reg & (opcode_reg == OPC_RESUME);

   // Which operation is actually running on the array
   wire prog_susp    = ps1_reg | ps2_reg;
   wire prog_run     = prog_act_reg & ~prog_susp;
   wire erase_run    = erase_act_reg & ~es_reg;
   wire any_susp     = prog_susp | es_reg;
   // Program resumes before erase; erase waits for the program to finish
   wire res_prog     = prog_susp;
   wire res_erase    = es_reg & ~prog_act_reg;
   wire can_suspend  = (state_reg == ST_IDLE) & (prog_run | erase_run);
   wire can_resume   = (state_reg == ST_IDLE) & (res_prog | res_erase);
   wire start_susp   = susp_cmd & can_suspend;
   wire start_res    = resume_cmd & can_resume;
   wire cnt_end      = (cnt_reg == CNT_RST);
   wire susp_done    = (state_reg == ST_SUSPEND) & cnt_end;

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = (cnt_reg == CNT_RST) ? CNT_RST : cnt_reg - 8'h01;
      unique case (state_reg)
         ST_IDLE:
         begin
            if (start_susp)
            begin
               state_next = ST_SUSPEND;
               cnt_next   = SUSP_CYCLES - 8'h01;
            end
            else if (start_res)
            begin
               state_next = ST_RESUME;
               cnt_next   = RES_CYCLES - 8'h01;
            end
         end
         ST_SUSPEND:
         begin
            if (cnt_end)
            begin
               state_next = ST_IDLE;
            end
         end
         ST_RESUME:
         begin
            if (cnt_end)
            begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || reset_evt)
      begin
         state_reg <= ST_IDLE;
         cnt_reg   <= CNT_RST;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         tgt_prog_reg <= 1'b0;
      end
      else if (start_susp)
      begin
         tgt_prog_reg <= prog_run;  // Program wins when both could run
      end
      else if (start_res)
      begin
         tgt_prog_reg <= res_prog;
      end
   end

   // Program start checks: never into an erase-suspended sector
   wire prog_start  = OP_START & ~OP_REQ.is_erase;
   wire prog_abort  = prog_start & es_reg & (OP_REQ.sector == erase_sect_reg);
   wire prog_launch = prog_start & ~prog_abort;
   wire erase_start = OP_START & OP_REQ.is_erase;
   wire done_prog   = OP_DONE & prog_run;
   wire done_erase  = OP_DONE & ~prog_run & erase_run;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || reset_evt)
      begin
         prog_act_reg  <= 1'b0;
         prog_buf_reg  <= 1'b0;
         prog_page_reg <= 1'b0;
         prog_sect_reg <= SECTOR_RST;
         ps1_reg       <= 1'b0;
         ps2_reg       <= 1'b0;
      end
      else
      begin
         if (prog_launch)
         begin
            prog_act_reg  <= 1'b1;
            prog_buf_reg  <= OP_REQ.buf_two;
            prog_page_reg <= OP_REQ.page_level;
            prog_sect_reg <= OP_REQ.sector;
         end
         else if (done_prog)
         begin
            prog_act_reg <= 1'b0;
         end
         if (susp_done && tgt_prog_reg)
         begin
            ps1_reg <= ~prog_buf_reg;
            ps2_reg <= prog_buf_reg;
         end
         else if (start_res && res_prog)
         begin
            ps1_reg <= 1'b0;
            ps2_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || reset_evt)
      begin
         erase_act_reg  <= 1'b0;
         erase_page_reg <= 1'b0;
         erase_sect_reg <= SECTOR_RST;
         es_reg         <= 1'b0;
      end
      else
      begin
         if (erase_start)
         begin
            erase_act_reg  <= 1'b1;
            erase_page_reg <= OP_REQ.page_level;
            erase_sect_reg <= OP_REQ.sector;
         end
         else if (done_erase)
         begin
            erase_act_reg <= 1'b0;
         end
         if (susp_done && !tgt_prog_reg)
         begin
            es_reg <= 1'b1;
         end
         else if (start_res && !res_prog)
         begin
            es_reg <= 1'b0;
         end
      end
   end

   // Suspend permission table
   wire own_buf_busy = CMD_REQ.buf_two ? ps2_reg : ps1_reg;
   wire cls_buf_side = (CMD_REQ.cls == CMD_BUF_WRITE) | (CMD_REQ.cls == CMD_MM_TO_BUF);
   wire cls_never    = (CMD_REQ.cls == CMD_PROG_WITH_ERS) | (CMD_REQ.cls == CMD_AUTO_REWRITE)
                     | (CMD_REQ.cls == CMD_ERASE_ANY);
   wire cls_guarded  = (CMD_REQ.cls == CMD_PROT_CHANGE) | (CMD_REQ.cls == CMD_POWER_DOWN);
   wire refuse_buf   = cls_buf_side & own_buf_busy;
   wire refuse_cmp   = (CMD_REQ.cls == CMD_MM_COMPARE) & own_buf_busy;
   wire refuse_pne   = (CMD_REQ.cls == CMD_PROG_NO_ERS) & prog_susp;
   wire refuse_all   = any_susp & cls_never;
   wire refuse_prot  = any_susp & cls_guarded;
   // Reads, info reads and resets fall through as permitted
   wire cmd_refused  = refuse_buf | refuse_cmp | refuse_pne | refuse_all | refuse_prot;

   // Undefined data whenever the read address sits in a suspended sector
   wire rd_bad = (es_reg & (RD_SECTOR == erase_sect_reg))
               | (prog_susp & (RD_SECTOR == prog_sect_reg));

   // Loss report on reset; an erase suspend is the wider loss
   wire    lose_any  = (SW_RESET | rstp_fall) & any_susp;
   undef_t lose_info;
   assign lose_info.page_level   = es_reg ? erase_page_reg : prog_page_reg;
   assign lose_info.whole_sector = es_reg & ~erase_page_reg;
   assign lose_info.sector       = es_reg ? erase_sect_reg : prog_sect_reg;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         CMD_ACCEPT  <= 1'b0;
         CMD_REFUSE  <= 1'b0;
         OP_ABORT    <= 1'b0;
         RD_UNDEF    <= 1'b0;
         UNDEF_VALID <= 1'b0;
         UNDEF_INFO  <= '0;
      end
      else
      begin
         CMD_ACCEPT  <= CMD_VALID & ~cmd_refused;
         CMD_REFUSE  <= CMD_VALID & cmd_refused;
         OP_ABORT    <= prog_abort;
         RD_UNDEF    <= rd_bad;
         UNDEF_VALID <= lose_any;
         if (lose_any)
         begin
            UNDEF_INFO <= lose_info;
         end
      end
   end

   // Flag and busy outputs; ready only once the halt has taken effect
   wire run_next = (prog_act_reg & ~prog_susp) | (erase_act_reg & ~es_reg)
                 | (state_reg == ST_SUSPEND);
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         HOLD_PROG              <= 1'b0;
         HOLD_ERASE             <= 1'b0;
         READY                  <= 1'b1;
         buf_one_prog_suspended <= 1'b0;
         buf_two_prog_suspended <= 1'b0;
         erase_suspended_flag   <= 1'b0;
      end
      else
      begin
         HOLD_PROG              <= prog_susp | ((state_reg == ST_SUSPEND) & tgt_prog_reg);
         HOLD_ERASE             <= es_reg | ((state_reg == ST_SUSPEND) & ~tgt_prog_reg);
         READY                  <= ~run_next;
         buf_one_prog_suspended <= ps1_reg;
         buf_two_prog_suspended <= ps2_reg;
         erase_suspended_flag   <= es_reg;
      end
   end

endmodule // flash_program_erase_suspend

`default_nettype wire

// ---- inc/suspend_pkg.sv ----
`default_nettype none

package suspend_pkg;

   // Opcodes handled by this block
   localparam logic [7:0] OPC_SUSPEND    = 8'hB0;
   localparam logic [7:0] OPC_RESUME     = 8'hD0;

   // Core clock and latency figures
   localparam int         CORE_CLK_MHZ   = 125;
   localparam int         SUSP_TIME_NS   = 1000;  // suspend_latency, plain default
   localparam int         RES_TIME_NS    = 1000;  // resume_latency, plain default
   localparam int         CNT_W          = 8;

   // Longest times round down, never below one cycle
   localparam int         SUSP_CYC_I     = (SUSP_TIME_NS * CORE_CLK_MHZ) / 1000;
   localparam int         RES_CYC_I      = (RES_TIME_NS * CORE_CLK_MHZ) / 1000;
   localparam logic [CNT_W-1:0] SUSP_CYCLES = CNT_W'((SUSP_CYC_I < 1) ? 1 : SUSP_CYC_I);
   localparam logic [CNT_W-1:0] RES_CYCLES  = CNT_W'((RES_CYC_I < 1) ? 1 : RES_CYC_I);

   // 64KB sectors: 64 of them in the main array
   localparam int         SECTOR_W       = 6;
   localparam int         BIT_CNT_W      = 3;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

   // Reset values
   localparam logic [SECTOR_W-1:0] SECTOR_RST = 6'h00;
   localparam logic [CNT_W-1:0]    CNT_RST    = 8'h00;
   localparam logic [7:0]          BYTE_RST   = 8'h00;

   typedef enum logic [3:0]
   {
      CMD_READ_ARRAY   = 4'h0,
      CMD_READ_BUF     = 4'h1,
      CMD_BUF_WRITE    = 4'h2,
      CMD_MM_TO_BUF    = 4'h3,
      CMD_MM_COMPARE   = 4'h4,
      CMD_PROG_NO_ERS  = 4'h5,
      CMD_PROG_WITH_ERS= 4'h6,
      CMD_AUTO_REWRITE = 4'h7,
      CMD_ERASE_ANY    = 4'h8,
      CMD_PROT_CHANGE  = 4'h9,
      CMD_PROT_READ    = 4'hA,
      CMD_POWER_DOWN   = 4'hB,
      CMD_INFO_READ    = 4'hC,
      CMD_RESET        = 4'hD
   } cmd_class_t;

   typedef struct packed
   {
      cmd_class_t cls;
      logic       buf_two;      // 0: buffer 1, 1: buffer 2
   } cmd_req_t;

   typedef struct packed
   {
      logic                is_erase;
      logic                buf_two;
      logic                page_level;
      logic [SECTOR_W-1:0] sector;
   } op_req_t;

   typedef struct packed
   {
      logic                whole_sector;  // 0: only the page is lost
      logic                page_level;
      logic [SECTOR_W-1:0] sector;
   } undef_t;

endpackage

`default_nettype wire

// ---- tb/flash_program_erase_suspend_properties.sv ----
`timescale 1ns/10ps
`default_nettype none

module suspend_properties
   import suspend_pkg::*;
(
   input wire logic     CORE_CLK,               // Core clock
   input wire logic     RST_N,                  // Reset, active low
   input wire logic     SW_RESET,               // Software reset pulse
   input wire logic     CMD_VALID,              // Command offered
   input wire cmd_req_t CMD_REQ,                // Command class
   input wire logic     OP_START,               // Operation start
   input wire op_req_t  OP_REQ,                 // Operation kind
   input wire logic     CMD_ACCEPT,             // Permitted
   input wire logic     CMD_REFUSE,             // Refused
   input wire logic     OP_ABORT,               // Program aborted
   input wire logic     HOLD_PROG,              // Program halted
   input wire logic     HOLD_ERASE,             // Erase halted
   input wire logic     READY,                  // Ready flag
   input wire logic     buf_one_prog_suspended, // Buffer-1 suspend
   input wire logic     buf_two_prog_suspended, // Buffer-2 suspend
   input wire logic     erase_suspended_flag,   // Erase suspend
   input wire logic     RD_UNDEF,               // Read undefined
   input wire logic     UNDEF_VALID             // Contents lost
);
   wire logic ps_any  = buf_one_prog_suspended | buf_two_prog_suspended;
   wire logic susp    = ps_any | erase_suspended_flag;
   wire logic own_ps  = CMD_REQ.buf_two ? buf_two_prog_suspended : buf_one_prog_suspended;
   wire logic buf_cmd = CMD_REQ.cls inside {CMD_BUF_WRITE, CMD_MM_TO_BUF, CMD_MM_COMPARE};
   wire logic ok_cmd  = CMD_REQ.cls inside {CMD_READ_ARRAY, CMD_READ_BUF, CMD_PROT_READ,
                                            CMD_INFO_READ, CMD_RESET};
   wire logic bad_cmd = CMD_REQ.cls inside {CMD_PROG_WITH_ERS, CMD_AUTO_REWRITE,
                                            CMD_ERASE_ANY, CMD_PROT_CHANGE, CMD_POWER_DOWN};
   wire logic ers_op  = OP_REQ.is_erase;

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);

   // Halt begins well before the flag may show
   sequence s_halt_begins;
      $rose(HOLD_ERASE);
   endsequence
   sequence s_flag_held_off;
      !erase_suspended_flag [*8];
   endsequence

   AST_ONE_ANSWER: assert property (CMD_VALID |=> CMD_ACCEPT != CMD_REFUSE)
      else $error("command answer missing or doubled");
   AST_NO_STRAY: assert property (!CMD_VALID |=> !CMD_ACCEPT && !CMD_REFUSE)
      else $error("answer without a command");
   AST_ALWAYS_OK: assert property (CMD_VALID && ok_cmd |=> CMD_ACCEPT)
      else $error("read or reset class refused");
   AST_NEVER_OK: assert property (CMD_VALID && susp && bad_cmd |=> CMD_REFUSE)
      else $error("forbidden class accepted while suspended");
   AST_OWN_BUF: assert property (CMD_VALID && buf_cmd |=> CMD_REFUSE == own_ps)
      else $error("buffer command permission wrong");
   AST_NO_ERS: assert property (CMD_VALID && CMD_REQ.cls == CMD_PROG_NO_ERS
                                |=> CMD_REFUSE == ps_any)
      else $error("program without erase permission wrong");
   AST_READY: assert property ($rose(buf_one_prog_suspended) || $rose(buf_two_prog_suspended)
                               || $rose(erase_suspended_flag) |-> READY)
      else $error("suspend flag set without ready");
   AST_HOLD: assert property ((erase_suspended_flag -> HOLD_ERASE) && (ps_any -> HOLD_PROG))
      else $error("suspended operation not halted");
   AST_LATENCY: assert property (s_halt_begins |-> s_flag_held_off)
      else $error("erase flag set too early");
   AST_ABORT: assert property (OP_ABORT |-> $past(OP_START) && !$past(ers_op)
                               && $past(erase_suspended_flag))
      else $error("abort without program into erase suspend");
   AST_LOSS: assert property (SW_RESET && susp |=> UNDEF_VALID)
      else $error("reset during suspend not reported");
   AST_RD_UNDEF: assert property (RD_UNDEF |-> $past(susp))
      else $error("read undefined with nothing suspended");

endmodule // suspend_properties

bind flash_program_erase_suspend suspend_properties chk
(
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .SW_RESET(SW_RESET), .CMD_VALID(CMD_VALID),
   .CMD_REQ(CMD_REQ), .OP_START(OP_START), .OP_REQ(OP_REQ), .CMD_ACCEPT(CMD_ACCEPT),
   .CMD_REFUSE(CMD_REFUSE), .OP_ABORT(OP_ABORT), .HOLD_PROG(HOLD_PROG),
   .HOLD_ERASE(HOLD_ERASE), .READY(READY), .buf_one_prog_suspended(buf_one_prog_suspended),
   .buf_two_prog_suspended(buf_two_prog_suspended),
   .erase_suspended_flag(erase_suspended_flag), .RD_UNDEF(RD_UNDEF), .UNDEF_VALID(UNDEF_VALID)
);

`default_nettype wire

// ---- tb/spi_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module spi_host_model
(
   output var logic sck,  // Serial clock, still between frames
   output var logic cs_n, // Chip select, idle high
   output var logic si    // Serial data to device
);
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b1;
   end

   // Opcode, then a trailing junk byte when extra is set; that byte must be ignored
   task automatic send(input logic [7:0] opc, input logic extra);
      logic [15:0] sh;
      sh = {opc, 8'hA5};
      cs_n = 1'b0;
      for (int i = 15; i >= (extra ? 0 : 8); i--)
      begin
         si = sh[i];
         #32 sck = 1'b1;
         #32 sck = 1'b0;
      end
      #32 cs_n = 1'b1;
      si = ~si; // Released line must not keep a stale bit
   endtask

endmodule // spi_host_model

`default_nettype wire

// ---- tb/flash_program_erase_suspend_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module flash_program_erase_suspend_test;
   import suspend_pkg::*;

   logic                clk, rst_n, sw_rst, rpin_n, cv, ops, opd;
   logic                acc, rfs, abt, hp, he, rdy, p1, p2, es, rdu, uv;
   logic [SECTOR_W-1:0] rds;
   cmd_req_t            cq;
   op_req_t             oq;
   undef_t              ui;
   wire logic           sck, cs_n, si;
   int                  bad_count, num_checks;
   logic                ab;

   spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si));

   flash_program_erase_suspend dut
   (
      .CORE_CLK(clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .SI(si),
      .RESET_PIN_N(rpin_n), .SW_RESET(sw_rst), .CMD_VALID(cv), .CMD_REQ(cq),
      .OP_START(ops), .OP_REQ(oq), .OP_DONE(opd), .RD_SECTOR(rds),
      .CMD_ACCEPT(acc), .CMD_REFUSE(rfs), .OP_ABORT(abt), .HOLD_PROG(hp),
      .HOLD_ERASE(he), .READY(rdy), .buf_one_prog_suspended(p1),
      .buf_two_prog_suspended(p2), .erase_suspended_flag(es), .RD_UNDEF(rdu),
      .UNDEF_VALID(uv), .UNDEF_INFO(ui)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [3:0] c, input logic b, input logic e);
      cq = '{cmd_class_t'(c), b};
      cv = 1'b1;
      @(negedge clk);
      // Answer stands for one cycle only
      chk({6'h00, acc, rfs}, {6'h00, e, !e});
      cv = 1'b0;
      @(negedge clk);
   endtask

   // Bit i of a mask: class i accepted on that buffer
   task automatic perm(input logic [13:0] m1, input logic [13:0] m2);
      for (int i = 0; i < 14; i++)
      begin
         cmd(4'(i), 1'b0, m1[i]);
         cmd(4'(i), 1'b1, m2[i]);
      end
   endtask

   task automatic op(input logic e, input logic b, input logic pg, input logic [5:0] s,
                     output logic a);
      oq = '{e, b, pg, s};
      ops = 1'b1;
      @(negedge clk);
      a = abt;
      ops = 1'b0;
      @(negedge clk);
   endtask

   // Fixed wait: frame end to flag is a set latency
   task automatic frame(input logic [7:0] opc);
      host.send(opc, 1'b1);
      repeat (140) @(negedge clk);
   endtask

   task automatic rd(input logic [5:0] s, input logic e);
      rds = s;
      @(negedge clk);
      chk({7'h00, rdu}, {7'h00, e});
   endtask

   initial
   begin
      {rst_n, sw_rst, cv, ops, opd} = 5'h00;
      rpin_n = 1'b1;
      cq = '0;
      oq = '0;
      rds = SECTOR_RST;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk({3'h0, rdy, he, es, p1, p2}, 8'h10);
      perm(14'h3FFF, 14'h3FFF);
      op(1'b1, 1'b0, 1'b0, 6'h05, ab);
      @(negedge clk);
      chk({7'h00, rdy}, 8'h00);
      frame(OPC_SUSPEND);
      chk({3'h0, rdy, he, es, p1, p2}, 8'h1C);
      perm(14'h343F, 14'h343F);
      op(1'b0, 1'b0, 1'b0, 6'h05, ab);
      chk({7'h00, ab}, 8'h01);
      op(1'b0, 1'b0, 1'b0, 6'h09, ab);
      chk({7'h00, ab}, 8'h00);
      frame(OPC_SUSPEND);
      chk({3'h0, rdy, hp, es, p1, p2}, 8'h1E);
      perm(14'h3403, 14'h341F);
      rd(6'h05, 1'b1);
      rd(6'h09, 1'b1);
      rd(6'h06, 1'b0);
      frame(OPC_RESUME);
      chk({3'h0, rdy, es, p1, p2, hp}, 8'h08);
      opd = 1'b1;
      @(negedge clk);
      opd = 1'b0;
      repeat (4) @(negedge clk);
      chk({7'h00, rdy}, 8'h01);
      host.send(OPC_RESUME, 1'b0);
      // Suspend lands inside the resume window and must be ignored
      repeat (4) @(negedge clk);
      host.send(OPC_SUSPEND, 1'b0);
      repeat (140) @(negedge clk);
      chk({5'h00, rdy, es, he}, 8'h00);
      frame(OPC_SUSPEND);
      chk({7'h00, es}, 8'h01);
      sw_rst = 1'b1;
      @(negedge clk);
      sw_rst = 1'b0;
      chk({7'h00, uv}, 8'h01);
      @(negedge clk);
      chk(ui, 8'h85);
      repeat (3) @(negedge clk);
      chk({5'h00, es, p1, p2}, 8'h00);
      op(1'b0, 1'b1, 1'b1, 6'h0C, ab);
      frame(OPC_SUSPEND);
      chk({5'h00, es, p1, p2}, 8'h01);
      rpin_n = 1'b0;
      for (int n = 0; n < 8 && uv !== 1'b1; n++)
         @(negedge clk);
      chk({7'h00, uv}, 8'h01);
      chk(ui, 8'h4C);
      rpin_n = 1'b1;
      repeat (4) @(negedge clk);
      chk({5'h00, es, p1, p2}, 8'h00);
      summarize();
   end

   initial
   begin
      #100000;
      bad_count++;
      summarize();
   end

endmodule // flash_program_erase_suspend_test

`default_nettype wire
